// file: logic/ascp_host.sv
`timescale 1ns/10ps
`include "ascp_cfg.svh"
`default_nettype none
module ascp_fifo #(
  parameter int WIDTH = `ASCP_RES_BITS,
  parameter int DEPTH = `ASCP_FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;
  logic [AW:0]      next_count;

  assign do_wr      = in_valid & in_ready;
  assign do_rd      = out_valid & out_ready;
  assign next_count = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
  assign out_data   = mem[rd_ptr];

  always_ff @(posedge clock)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr    <= wr_ptr + AW'(do_wr);
      rd_ptr    <= rd_ptr + AW'(do_rd);
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule

module ascp_host (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  ascp_if.host                         link,
  input  wire logic                    spi_cpol,
  input  wire logic                    spi_cpha,
  input  wire logic                    byte_mode,
  input  wire logic                    cmd_valid,
  input  wire ascp_pkg::ascp_cmd_e     cmd_code,
  output logic                         cmd_ready,
  output logic                         res_valid,
  output ascp_pkg::ascp_result_t       res_data,
  input  wire logic                    res_ready
);
  ascp_pkg::ascp_host_state_e hst;
  ascp_pkg::ascp_cmd_e        cur;
  ascp_pkg::ascp_cmd_e        pend_code;
  ascp_pkg::ascp_result_t     push_data;
  logic       pend_valid;
  logic       discard;
  logic [2:0] half;
  logic [4:0] edge_cnt;
  logic [15:0] sh;
  logic       sclk_q;
  logic       cs_q;
  logic       lrst_q;
  logic       dout_meta;
  logic       dout_sync;
  logic       push;
  logic       fifo_in_ready;
  logic       half_done;
  logic       at_end;
  logic       stall;
  logic       fall;
  logic       take;
  logic       launch;
  logic       chain;
  logic       mode_rise;

  assign link.sclk               = sclk_q;
  assign link.conversion_start_n = cs_q;
  assign link.link_rst           = lrst_q;

  assign half_done = half == `ASCP_HALF_LAST;
  assign at_end    = edge_cnt == `ASCP_FRAME_CLKS;
  // a full result store holds the clock high rather than lose a word
  assign stall     = at_end & ~discard & (cur != ascp_pkg::ASCP_CMD_PWRDN) & ~fifo_in_ready;
  assign fall      = (hst == ascp_pkg::ASCP_H_HIGH) & half_done & ~stall;
  assign take      = cmd_valid & cmd_ready;
  assign chain     = fall & at_end & (cur == ascp_pkg::ASCP_CMD_CONT) & pend_valid &
                     (pend_code == ascp_pkg::ASCP_CMD_CONT);
  assign launch    = ((hst == ascp_pkg::ASCP_H_IDLE) & pend_valid) | chain;
  assign mode_rise = spi_cpol == spi_cpha;

  always_ff @(posedge clock)
  begin
    dout_meta <= link.dout_data;
    dout_sync <= dout_meta;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pend_valid <= 1'b0;
      pend_code  <= ascp_pkg::ASCP_CMD_SINGLE;
      cmd_ready  <= 1'b0;
    end
    else
    begin
      if (launch)
      begin
        pend_valid <= 1'b0;
      end
      else if (take)
      begin
        pend_valid <= 1'b1;
        pend_code  <= cmd_code;
      end
      cmd_ready <= ~take & (launch | ~pend_valid) & (hst != ascp_pkg::ASCP_H_INIT);
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sh <= 16'h0000;
    end
    else if (mode_rise ? ((hst == ascp_pkg::ASCP_H_LOW) & half_done) : fall)
    begin
      sh <= {sh[14:0], dout_sync};
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      push      <= 1'b0;
      push_data <= '0;
    end
    else
    begin
      push <= fall & at_end & ~discard & (cur != ascp_pkg::ASCP_CMD_PWRDN);
      // both capture modes leave the twelve result bits in the same place here
      push_data <= sh[11:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hst      <= ascp_pkg::ASCP_H_INIT;
      half     <= 3'h0;
      edge_cnt <= 5'h00;
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      lrst_q   <= 1'b1;
      cur      <= ascp_pkg::ASCP_CMD_SINGLE;
      discard  <= 1'b1;
    end
    else
    begin
      half <= (half_done && !stall) ? 3'h0 : ((half_done) ? half : half + 3'h1);
      case (hst)
        ascp_pkg::ASCP_H_INIT:
        begin
          // clocks with start high reset the far end, then a discarded first frame
          if (half_done)
          begin
            if (edge_cnt == `ASCP_INIT_CLKS && !sclk_q)
            begin
              lrst_q   <= 1'b0;
              cs_q     <= 1'b0;
              edge_cnt <= 5'h00;
              hst      <= ascp_pkg::ASCP_H_LOW;
            end
            else
            begin
              sclk_q <= ~sclk_q;
              if (!sclk_q)
              begin
                edge_cnt <= edge_cnt + 5'h01;
              end
            end
          end
        end
        ascp_pkg::ASCP_H_IDLE:
        begin
          half   <= 3'h0;
          sclk_q <= spi_cpol;
          cs_q   <= 1'b1;
          if (launch)
          begin
            cs_q     <= 1'b0;
            sclk_q   <= 1'b0;
            edge_cnt <= 5'h00;
            cur      <= pend_code;
            discard  <= 1'b0;
            hst      <= ascp_pkg::ASCP_H_LOW;
          end
        end
        ascp_pkg::ASCP_H_LOW:
        begin
          if (half_done)
          begin
            sclk_q   <= 1'b1;
            edge_cnt <= edge_cnt + 5'h01;
            hst      <= ascp_pkg::ASCP_H_HIGH;
          end
        end
        ascp_pkg::ASCP_H_HIGH:
        begin
          if (fall)
          begin
            sclk_q <= 1'b0;
            if (cur == ascp_pkg::ASCP_CMD_PWRDN && edge_cnt == `ASCP_BYTE_CLKS)
            begin
              cs_q <= 1'b1;
            end
            if (cur == ascp_pkg::ASCP_CMD_CONT && edge_cnt == `ASCP_LSB_EDGE)
            begin
              cs_q <= 1'b1;
            end
            if (at_end)
            begin
              if (cur == ascp_pkg::ASCP_CMD_SINGLE)
              begin
                hst <= ascp_pkg::ASCP_H_TAIL;
              end
              else if (chain)
              begin
                cs_q     <= 1'b0;
                edge_cnt <= 5'h00;
                discard  <= 1'b0;
                hst      <= ascp_pkg::ASCP_H_LOW;
              end
              else
              begin
                hst <= ascp_pkg::ASCP_H_END;
              end
            end
            else if (edge_cnt == `ASCP_BYTE_CLKS && byte_mode &&
                     cur != ascp_pkg::ASCP_CMD_PWRDN)
            begin
              hst <= ascp_pkg::ASCP_H_GAP;
            end
            else
            begin
              hst <= ascp_pkg::ASCP_H_LOW;
            end
          end
        end
        ascp_pkg::ASCP_H_GAP:
        begin
          if (half_done)
          begin
            hst <= ascp_pkg::ASCP_H_LOW;
          end
        end
        ascp_pkg::ASCP_H_TAIL:
        begin
          if (half_done)
          begin
            sclk_q <= 1'b1;
            hst    <= ascp_pkg::ASCP_H_END;
          end
        end
        ascp_pkg::ASCP_H_END:
        begin
          // the far end sees start only at clock rises: one rise with start
          // high re-arms its falling-edge detector before the clock stops
          if (half_done)
          begin
            cs_q <= 1'b1;
            if (sclk_q)
            begin
              sclk_q <= 1'b0;
            end
            else if (cs_q)
            begin
              sclk_q <= 1'b1;
              hst    <= ascp_pkg::ASCP_H_IDLE;
            end
          end
        end
        default:
        begin
          hst <= ascp_pkg::ASCP_H_IDLE;
        end
      endcase
    end
  end

  ascp_fifo #(
    .WIDTH (`ASCP_RES_BITS),
    .DEPTH (`ASCP_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );
endmodule
`default_nettype wire

// file: logic/ascp_cfg.svh
`ifndef ASCP_CFG_SVH
`define ASCP_CFG_SVH

`define ASCP_CLK_KHZ       40000
`define ASCP_SCLK_MAX_KHZ  28800
`define ASCP_SCLK_KHZ      5000
`define ASCP_SCLK_HALF     ((`ASCP_CLK_KHZ + 2 * `ASCP_SCLK_KHZ - 1) / (2 * `ASCP_SCLK_KHZ))
`define ASCP_HALF_LAST     3'(`ASCP_SCLK_HALF - 1)
`define ASCP_RES_BITS      12
`define ASCP_FIFO_DEPTH    16
`define ASCP_FRAME_CLKS    5'h10
`define ASCP_HOLD_EDGE     5'h03
`define ASCP_MSB_EDGE      5'h04
`define ASCP_LSB_EDGE      5'h0f
`define ASCP_PD_FIRST      5'h04
`define ASCP_PD_LAST       5'h0d
`define ASCP_WAKE_EDGE     5'h0e
`define ASCP_BYTE_CLKS     5'h08
`define ASCP_INIT_CLKS     5'h08

`endif

// file: logic/ascp_pkg.sv
`include "ascp_cfg.svh"
package ascp_pkg;
  typedef logic [`ASCP_RES_BITS-1:0] ascp_result_t;
  typedef enum logic [1:0] {
    ASCP_PWR_ON      = 2'h0,
    ASCP_PWR_PARTIAL = 2'h1,
    ASCP_PWR_FULL    = 2'h2
  } ascp_pwr_e;
  typedef enum logic [1:0] {
    ASCP_CMD_SINGLE = 2'h0,
    ASCP_CMD_CONT   = 2'h1,
    ASCP_CMD_PWRDN  = 2'h2
  } ascp_cmd_e;
  typedef enum logic [1:0] {
    ASCP_DEV_IDLE = 2'h0,
    ASCP_DEV_CONV = 2'h1,
    ASCP_DEV_TAIL = 2'h2,
    ASCP_DEV_LAST = 2'h3
  } ascp_dev_state_e;
  typedef enum logic [2:0] {
    ASCP_H_INIT = 3'h0,
    ASCP_H_IDLE = 3'h1,
    ASCP_H_LOW  = 3'h2,
    ASCP_H_HIGH = 3'h3,
    ASCP_H_GAP  = 3'h4,
    ASCP_H_TAIL = 3'h5,
    ASCP_H_END  = 3'h6
  } ascp_host_state_e;
endpackage

// file: logic/ascp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ascp_if;
  logic sclk;
  logic conversion_start_n;
  logic link_rst;
  logic dout_data;
  logic dout_oe_n;

  modport dev (
    input  sclk,
    input  conversion_start_n,
    input  link_rst,
    output dout_data,
    output dout_oe_n
  );
  modport host (
    output sclk,
    output conversion_start_n,
    output link_rst,
    input  dout_data,
    input  dout_oe_n
  );
endinterface
`default_nettype wire

// file: logic/ascp_dev.sv
`timescale 1ns/10ps
`include "ascp_cfg.svh"
`default_nettype none
// whole end runs on the link clock; start is launched by the host on falling
// serial clock edges or while the clock is low, so it is stable at every rising edge and needs no synchroniser
module ascp_dev (
  ascp_if.dev                        link,
  input  wire logic [`ASCP_RES_BITS-1:0] sample_value,
  output ascp_pkg::ascp_pwr_e        power_state
);
  ascp_pkg::ascp_dev_state_e state;
  ascp_pkg::ascp_result_t    samp_meta;
  ascp_pkg::ascp_result_t    samp_sync;
  ascp_pkg::ascp_result_t    held;
  logic [4:0]                cnt;
  logic [4:0]                n;
  logic                      cs_prev;
  logic                      start;
  logic                      dout_q;
  logic                      oe_n_q;

  function automatic logic frame_bit(input logic [4:0] e, input ascp_pkg::ascp_result_t s);
    logic [4:0] idx;
    begin
      idx = 5'h0f - e;
      frame_bit = (e >= `ASCP_MSB_EDGE && e <= `ASCP_LSB_EDGE) ? s[idx[3:0]] : 1'b0;
    end
  endfunction

  assign n      = cnt + 5'h01;
  assign start  = cs_prev & ~link.conversion_start_n;
  assign link.dout_data = dout_q;
  assign link.dout_oe_n = oe_n_q;

  // slow analog value; a torn word is at worst one stale sample
  always_ff @(posedge link.sclk)
  begin
    samp_meta <= sample_value;
    samp_sync <= samp_meta;
  end

  always_ff @(posedge link.sclk)
  begin
    if (link.link_rst)
    begin
      state       <= ascp_pkg::ASCP_DEV_IDLE;
      cnt         <= 5'h00;
      cs_prev     <= 1'b1;
      held        <= '0;
      dout_q      <= 1'b0;
      oe_n_q      <= 1'b1;
      power_state <= ascp_pkg::ASCP_PWR_ON;
    end
    else
    begin
      cs_prev <= link.conversion_start_n;
      case (state)
        ascp_pkg::ASCP_DEV_IDLE, ascp_pkg::ASCP_DEV_TAIL:
        begin
          if (start)
          begin
            state  <= ascp_pkg::ASCP_DEV_CONV;
            cnt    <= 5'h01;
            dout_q <= 1'b0;
            oe_n_q <= 1'b0;
          end
          else if (state == ascp_pkg::ASCP_DEV_IDLE)
          begin
            oe_n_q <= 1'b1;
          end
        end
        ascp_pkg::ASCP_DEV_CONV:
        begin
          cnt <= n;
          if (n == `ASCP_HOLD_EDGE)
          begin
            // the synchroniser only moves on clock rises, so the value is
            // taken once two rises of this frame have refreshed it
            held <= samp_sync;
          end
          if (n == `ASCP_WAKE_EDGE)
          begin
            power_state <= ascp_pkg::ASCP_PWR_ON;
          end
          if (link.conversion_start_n && n < `ASCP_PD_FIRST)
          begin
            state  <= ascp_pkg::ASCP_DEV_IDLE;
            oe_n_q <= 1'b1;
          end
          else if (link.conversion_start_n && n <= `ASCP_PD_LAST)
          begin
            state  <= ascp_pkg::ASCP_DEV_IDLE;
            oe_n_q <= 1'b1;
            power_state <= (power_state == ascp_pkg::ASCP_PWR_ON) ?
                           ascp_pkg::ASCP_PWR_PARTIAL : ascp_pkg::ASCP_PWR_FULL;
          end
          else
          begin
            dout_q <= frame_bit(n, held);
            if (n == `ASCP_FRAME_CLKS)
            begin
              // high inside the window keeps the line driven for the next frame
              state <= link.conversion_start_n ? ascp_pkg::ASCP_DEV_TAIL :
                       ascp_pkg::ASCP_DEV_LAST;
            end
          end
        end
        ascp_pkg::ASCP_DEV_LAST:
        begin
          // cannot see the start rising without a clock edge: released on the next one
          state  <= ascp_pkg::ASCP_DEV_IDLE;
          oe_n_q <= 1'b1;
        end
        default:
        begin
          state  <= ascp_pkg::ASCP_DEV_IDLE;
          oe_n_q <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: sim/ascp_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ascp_asserts (
  input wire logic sclk,
  input wire logic conversion_start_n,
  input wire logic link_rst,
  input wire logic dout_data,
  input wire logic dout_oe_n
);
  logic [4:0] cnt;
  logic       neg_oe;
  logic       neg_dat;

  // rises seen with start low; saturates so a long low tail stays covered
  always_ff @(posedge sclk)
  begin
    if (link_rst || conversion_start_n)
      cnt <= 5'h00;
    else if (cnt != 5'h1f)
      cnt <= cnt + 5'h01;
  end

  // output as seen mid-cycle, to prove it does not move before the rise
  always_ff @(negedge sclk)
  begin
    neg_oe  <= dout_oe_n;
    neg_dat <= dout_data;
  end

  a_first_low: assert property (@(negedge sclk) disable iff (link_rst)
    cnt == 5'h01 |-> !dout_oe_n && !dout_data) else $error("output not low after start");
  a_lead_zeros: assert property (@(negedge sclk) disable iff (link_rst)
    cnt >= 5'h02 && cnt <= 5'h03 |-> !dout_oe_n && !dout_data) else $error("leading bit wrong");
  a_data_driven: assert property (@(negedge sclk) disable iff (link_rst)
    cnt >= 5'h04 && cnt <= 5'h0f |-> !dout_oe_n) else $error("output released mid frame");
  a_trailing_zero: assert property (@(negedge sclk) disable iff (link_rst)
    cnt == 5'h10 |-> !dout_oe_n && !dout_data) else $error("trailing bit wrong");
  a_late_release: assert property (@(negedge sclk) disable iff (link_rst)
    cnt >= 5'h11 |-> dout_oe_n) else $error("output not released after frame");
  a_idle_hold: assert property (@(negedge sclk) disable iff (link_rst)
    $past(dout_oe_n) && conversion_start_n |-> dout_oe_n) else $error("output driven while idle");
  a_rise_only: assert property (@(posedge sclk) disable iff (link_rst)
    !dout_oe_n && !neg_oe |-> dout_data == neg_dat) else $error("output moved before rise");
  a_cont_driven: assert property (@(negedge sclk) disable iff (link_rst)
    $past(cnt) == 5'h0f && cnt == 5'h00 |-> !dout_oe_n && !dout_data)
    else $error("output not kept driven in chain");

  c_single: cover property (@(negedge sclk) disable iff (link_rst) cnt == 5'h11);
  c_chain: cover property (@(negedge sclk) disable iff (link_rst)
    $past(cnt) == 5'h0f && cnt == 5'h00);
  c_pwrdn: cover property (@(posedge sclk) disable iff (link_rst)
    $rose(conversion_start_n) && cnt == 5'h08);
endmodule
`default_nettype wire

// file: sim/tb_adc_serial_conversion_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_conversion_port;
  logic                   clock;
  logic                   sys_rst;
  logic                   spi_cpol;
  logic                   spi_cpha;
  logic                   byte_mode;
  logic                   cmd_valid;
  ascp_pkg::ascp_cmd_e    cmd_code;
  logic                   cmd_ready;
  logic                   res_valid;
  ascp_pkg::ascp_result_t res_data;
  logic                   res_ready;
  ascp_pkg::ascp_result_t sample_value;
  ascp_pkg::ascp_pwr_e    power_state;
  int                     num_errors;
  int                     check_count;
  ascp_pkg::ascp_result_t vals [8] = '{12'h000, 12'hfff, 12'h800, 12'h001,
                                       12'ha5a, 12'h5a5, 12'h7fe, 12'h123};

  ascp_if ascp_if_inst ();

  ascp_host ascp_host_inst (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .link      (ascp_if_inst),
    .spi_cpol  (spi_cpol),
    .spi_cpha  (spi_cpha),
    .byte_mode (byte_mode),
    .cmd_valid (cmd_valid),
    .cmd_code  (cmd_code),
    .cmd_ready (cmd_ready),
    .res_valid (res_valid),
    .res_data  (res_data),
    .res_ready (res_ready)
  );

  ascp_dev ascp_dev_inst (
    .link         (ascp_if_inst),
    .sample_value (sample_value),
    .power_state  (power_state)
  );

  ascp_asserts ascp_asserts_inst (
    .sclk               (ascp_if_inst.sclk),
    .conversion_start_n (ascp_if_inst.conversion_start_n),
    .link_rst           (ascp_if_inst.link_rst),
    .dout_data          (ascp_if_inst.dout_data),
    .dout_oe_n          (ascp_if_inst.dout_oe_n)
  );

  always #12.5 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // held until the negedge before the taking edge shows ready
  task automatic send_cmd(input ascp_pkg::ascp_cmd_e code);
    int n = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    do
      @(negedge clock);
    while (cmd_ready !== 1'b1 && n++ < 4000);
    check(16'(cmd_ready), 16'h0001);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask

  task automatic get_res(input ascp_pkg::ascp_result_t exp);
    int n = 0;
    do
      @(negedge clock);
    while (res_valid !== 1'b1 && n++ < 4000);
    check(16'(res_valid), 16'h0001);
    check(16'(res_data), 16'(exp));
    @(posedge clock);
    res_ready <= 1'b1;
    @(posedge clock);
    res_ready <= 1'b0;
  endtask

  task automatic wait_pwr(input ascp_pkg::ascp_pwr_e exp);
    int n = 0;
    do
      @(negedge clock);
    while (power_state !== exp && n++ < 800);
    check(16'(power_state), 16'(exp));
  endtask

  // a value is set well ahead so it is steady at the frame rises that load the two-stage sync
  task automatic single(input ascp_pkg::ascp_result_t v);
    @(posedge clock);
    sample_value <= v;
    repeat (32) @(posedge clock);
    send_cmd(ascp_pkg::ASCP_CMD_SINGLE);
  endtask

  initial
  begin
    repeat (40000) @(posedge clock);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    clock = 1'b0;
    num_errors = 0;
    check_count = 0;
    sys_rst <= 1'b1;
    {byte_mode, spi_cpol, spi_cpha} <= 3'h0;
    cmd_valid <= 1'b0;
    cmd_code <= ascp_pkg::ASCP_CMD_SINGLE;
    res_ready <= 1'b0;
    sample_value <= 12'h000;
    repeat (20) @(posedge clock);
    check(16'(ascp_if_inst.conversion_start_n), 16'h0001);
    check(16'(ascp_if_inst.sclk), 16'h0000);
    check(16'({cmd_ready, res_valid}), 16'h0000);
    sys_rst <= 1'b0;
    // every clock mode, each with and without byte framing
    for (int m = 0; m < 8; m++)
    begin
      repeat (64) @(posedge clock);
      {byte_mode, spi_cpol, spi_cpha} <= 3'(m);
      single(vals[m]);
      get_res(vals[m]);
      repeat (64) @(posedge clock);
      check(16'(ascp_if_inst.dout_oe_n), 16'h0001);
      check(16'(ascp_if_inst.conversion_start_n), 16'h0001);
    end
    @(posedge clock);
    sample_value <= 12'h3c5;
    repeat (32) @(posedge clock);
    send_cmd(ascp_pkg::ASCP_CMD_CONT);
    send_cmd(ascp_pkg::ASCP_CMD_CONT);
    get_res(12'h3c5);
    get_res(12'h3c5);
    send_cmd(ascp_pkg::ASCP_CMD_PWRDN);
    wait_pwr(ascp_pkg::ASCP_PWR_PARTIAL);
    send_cmd(ascp_pkg::ASCP_CMD_PWRDN);
    wait_pwr(ascp_pkg::ASCP_PWR_FULL);
    check(16'(ascp_if_inst.conversion_start_n), 16'h0001);
    single(12'h6e1);
    wait_pwr(ascp_pkg::ASCP_PWR_ON);
    get_res(12'h6e1);
    // fill the buffer past its depth with the reader stalled
    for (int i = 0; i < 17; i++)
    begin
      single(vals[i % 8] ^ 12'(i));
      repeat (200) @(posedge clock);
    end
    check(16'(res_valid), 16'h0001);
    check(16'(ascp_if_inst.sclk), 16'h0001);
    for (int i = 0; i < 17; i++)
      get_res(vals[i % 8] ^ 12'(i));
    print_verdict();
  end
endmodule
`default_nettype wire
